// file: design/utb_pkg.sv
// register map, field positions and reset values of the serial buffer block
package utb_pkg;
	// word indices; byte address is four times the index
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_STAT = 3'h1;
	localparam logic [2:0] REG_CTLB = 3'h2;
	localparam logic [2:0] REG_CTLC = 3'h3;
	localparam logic [2:0] REG_BAUD = 3'h4;
	// status_reg_a fields
	localparam int ST_RXC = 7;
	localparam int ST_TXC = 6;
	localparam int ST_UDRE = 5;
	localparam int ST_FE = 4;
	localparam int ST_DOR = 3;
	localparam int ST_PE = 2;
	// control_reg_b fields
	localparam int CB_TXCIE = 6;
	localparam int CB_UDRIE = 5;
	localparam int CB_RXEN = 4;
	localparam int CB_TX_ON = 3;
	localparam int CB_SZ2 = 2;
	localparam int CB_RX8 = 1;
	localparam int CB_TX8 = 0;
	// control_reg_c fields
	localparam int CC_SYNC = 6;
	localparam int CC_PEN = 5;
	localparam int CC_PODD = 4;
	localparam int CC_STOP2 = 3;
	localparam int CC_SZ_LO = 1;
	// reset values
	localparam logic [7:0] CTLB_RST = 8'h00;
	localparam logic [7:0] CTLC_RST = 8'h06;
	localparam logic [11:0] BAUD_RST = 12'h009;
	localparam logic [2:0] SZ_NINE = 3'h7;
	// receive fifo entry: {pe, dor, fe, ninth, data[7:0]}
	localparam int FIFO_W = 12;
	localparam int FIFO_DEPTH = 2;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} utb_rx_t;
endpackage

// file: design/utb_usart.sv
// serial transmitter/receiver buffers, flags and avalon register slave
// Notes on behaviour
// RL1 - buffer empty flag high when transmit buffer empty, low while data waits
// RL2 - software writes zero into the buffer empty flag position
// RL3 - buffer empty interrupt requested while enabled and flag set
// RL4 - writing the data port clears the buffer empty flag
// RL5 - handler writes data or disables the empty interrupt
// RL6 - complete flag sets when frame shifted out and buffer empty
// RL7 - complete flag clears on interrupt service or written one
// RL8 - complete interrupt raised when complete flag sets, if enabled
// RL9 - parity bit inserted after last data bit when enabled
// RL10 - transmitter disable waits for shifter and buffer empty, then releases pin
// RL11 - receiver enable takes over serial input pin
// RL12 - synchronous mode samples incoming bits on the sync clock
// RL13 - reception starts only on a valid start bit
// RL14 - second stop bit ignored, frame complete at first stop
// RL15 - at first stop bit the frame moves into the receive buffer
// RL16 - unused upper data bits read as zero
// RL17 - ninth bit and error flags stored per fifo entry, advance on read
// RL18 - software reads status and ninth bit before the data port
// RL19 - software sets transmit ninth bit before writing data port
// RL20 - transmitter ignores unused upper data bits
// RL21 - parity is xor of data bits, inverted for odd
// RL22 - frame is start, data lsb first, parity, one or two stops
// RL23 - receive buffer is a two-entry fifo, complete flag while non-empty
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module utb_usart #(
	parameter int ADDR_W = 3
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [3:0]        avs_byteenable_i,
	input  wire logic [31:0]       avs_writedata_i,
	output logic [31:0]            avs_readdata_o,
	output logic                   avs_waitrequest_o,
	// interrupt requests
	input  wire logic              global_irq_enable_i,
	input  wire logic              tx_complete_irq_ack_i,
	output logic                   tx_empty_irq_o,
	output logic                   tx_complete_irq_o,
	// line pins
	input  wire logic              serial_in_pin_i,
	input  wire logic              sync_clock_pin_i,
	output logic                   serial_out_pin_o,
	output logic                   serial_out_oe_o,
	output logic                   serial_in_owned_o
);
	initial begin
		if (ADDR_W < 3) $error("ADDR_W must be at least 3");
	end

	function automatic logic [3:0] nbits(input logic [2:0] sz);
		nbits = (sz == utb_pkg::SZ_NINE) ? 4'd9 : 4'(sz[1:0]) + 4'd5;
	endfunction

	function automatic logic [8:0] dmask(input logic [8:0] d, input logic [3:0] n);
		dmask = d & 9'((10'h001 << n) - 10'h001);
	endfunction

	function automatic logic parity(input logic [8:0] d, input logic [3:0] n,
			input logic odd);
		parity = ^dmask(d, n) ^ odd;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// configuration and pin synchronisers
	logic [7:0]  ctlb_q;
	logic [7:0]  ctlc_q;
	logic [11:0] baud_q;
	logic [1:0]  rxd_s_q, sck_s_q;
	logic        sck_p_q;
	logic        ack_q;
	logic [31:0] rdata_q;

	wire [2:0] size_w = {ctlb_q[utb_pkg::CB_SZ2], ctlc_q[utb_pkg::CC_SZ_LO +: 2]};
	wire [3:0] n_w = nbits(size_w);
	wire pen_w = ctlc_q[utb_pkg::CC_PEN];
	wire podd_w = ctlc_q[utb_pkg::CC_PODD];
	wire sync_w = ctlc_q[utb_pkg::CC_SYNC];
	wire rxen_w = ctlb_q[utb_pkg::CB_RXEN];
	wire rxd_w = rxd_s_q[1];
	wire sck_rise_w = sck_s_q[1] & ~sck_p_q;
	wire sck_fall_w = ~sck_s_q[1] & sck_p_q;

	always_ff @(posedge clk_i) begin
		rxd_s_q <= {rxd_s_q[0], serial_in_pin_i};
		sck_s_q <= {sck_s_q[0], sync_clock_pin_i};
		sck_p_q <= sck_s_q[1];
	end

	////////////////////////////////////////////////////////////////////////
	// bus decode: one wait state, effects at the edge where waitrequest is low
	wire req_w = avs_read_i | avs_write_i;
	wire acc_w = req_w & ack_q;
	wire be0_w = avs_byteenable_i[0];
	wire wr_w = avs_write_i & ack_q & be0_w;
	wire [2:0] ra_w = avs_address_i[2:0];
	wire hi_zero_w = (avs_address_i >> 3) == '0;
	wire wr_data_w = wr_w & hi_zero_w & (ra_w == utb_pkg::REG_DATA);
	wire wr_stat_w = wr_w & hi_zero_w & (ra_w == utb_pkg::REG_STAT);
	wire wr_ctlb_w = wr_w & hi_zero_w & (ra_w == utb_pkg::REG_CTLB);
	wire wr_ctlc_w = wr_w & hi_zero_w & (ra_w == utb_pkg::REG_CTLC);
	wire wr_baud_w = wr_w & hi_zero_w & (ra_w == utb_pkg::REG_BAUD);
	wire rd_data_w = avs_read_i & ack_q & hi_zero_w & (ra_w == utb_pkg::REG_DATA);
	wire [7:0] wd_w = avs_writedata_i[7:0];

	assign avs_waitrequest_o = req_w & ~ack_q;
	assign avs_readdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// transmitter
	logic [8:0]  tbuf_q;
	logic        tfull_q, tbusy_q, txc_q, txo_q;
	logic [12:0] tsh_q;
	logic [3:0]  tcnt_q;
	logic [11:0] tdiv_q;

	wire udre_w = ~tfull_q; // [RL1]
	// disable only takes hold once nothing is left to send
	wire tx_act_w = ctlb_q[utb_pkg::CB_TX_ON] | tbusy_q | tfull_q; // [RL10]
	wire ttick_w = sync_w ? sck_fall_w : (tdiv_q == 12'h000);
	// a byte still queued goes out after the enable drops; a write while off is sent as well
	wire tload_w = tfull_q & ~tbusy_q & tx_act_w; // [RL10]
	wire tlast_w = tbusy_q & ttick_w & (tcnt_q == 4'd1);
	wire [8:0] td_w = dmask(tbuf_q, n_w); // [RL20]
	wire tpar_w = parity(td_w, n_w, podd_w); // [RL21]
	// frame: start, data lsb first, parity, stop bits as trailing ones
	wire [12:0] tbase_w = (13'h1FFF << (n_w + 4'd1)) | {3'h0, td_w, 1'b0}; // [RL22]
	wire [12:0] tpbit_w = 13'h0001 << (n_w + 4'd1);
	wire [12:0] tframe_w = (pen_w & ~tpar_w) ? (tbase_w & ~tpbit_w) : tbase_w; // [RL9]
	wire [3:0] tlen_w = 4'd2 + n_w + 4'(pen_w) + 4'(ctlc_q[utb_pkg::CC_STOP2]); // [RL22]
	wire txc_set_w = tlast_w & ~tfull_q; // [RL6]
	wire txc_clr_w = (wr_stat_w & wd_w[utb_pkg::ST_TXC]) | tx_complete_irq_ack_i; // [RL7]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tfull_q <= 1'b0;
			tbuf_q <= 9'h000;
		end else if (wr_data_w & ~tfull_q) begin
			tfull_q <= 1'b1; // [RL4]
			tbuf_q <= {ctlb_q[utb_pkg::CB_TX8], wd_w}; // [RL19]
		end else if (tload_w) begin
			tfull_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tbusy_q <= 1'b0;
			tsh_q <= 13'h1FFF;
			tcnt_q <= 4'd0;
			txo_q <= 1'b1;
		end else if (tload_w) begin
			tbusy_q <= 1'b1;
			tsh_q <= {1'b1, tframe_w[12:1]};
			tcnt_q <= tlen_w;
			txo_q <= tframe_w[0];
		end else if (tbusy_q & ttick_w) begin
			tbusy_q <= ~tlast_w;
			tsh_q <= {1'b1, tsh_q[12:1]};
			tcnt_q <= tcnt_q - 4'd1;
			txo_q <= tlast_w ? 1'b1 : tsh_q[0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || tload_w || ttick_w) tdiv_q <= baud_q;
		else tdiv_q <= tdiv_q - 12'h001;
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) txc_q <= 1'b0;
		else if (txc_set_w) txc_q <= 1'b1; // [RL6]
		else if (txc_clr_w) txc_q <= 1'b0; // [RL7]
	end

	assign serial_out_pin_o = txo_q;
	assign serial_out_oe_o = tx_act_w; // [RL10]
	assign tx_empty_irq_o = global_irq_enable_i & ctlb_q[utb_pkg::CB_UDRIE] & udre_w; // [RL3]
	assign tx_complete_irq_o = global_irq_enable_i & ctlb_q[utb_pkg::CB_TXCIE] & txc_q; // [RL8]

	////////////////////////////////////////////////////////////////////////
	// receiver
	utb_pkg::utb_rx_t rst_q;
	logic [9:0]  rsh_q;
	logic [3:0]  ridx_q;
	logic [11:0] rdiv_q;
	logic        dor_pend_q;
	logic [utb_pkg::FIFO_W-1:0] fifo_q [utb_pkg::FIFO_DEPTH];
	logic        wp_q, rp_q;
	logic [1:0]  cnt_q;

	// the pin belongs to the receiver only while enabled
	assign serial_in_owned_o = rxen_w; // [RL11]
	wire rtick_w = sync_w ? sck_rise_w : (rdiv_q == 12'h000); // [RL12]
	wire [3:0] rlen_w = n_w + 4'(pen_w);
	wire done_w = (rst_q == utb_pkg::RX_STOP) & rtick_w; // [RL14]
	wire full_w = cnt_q == 2'd2;
	wire pop_w = rd_data_w & (cnt_q != 2'd0); // [RL17]
	wire push_w = done_w & (~full_w | pop_w) & rxen_w; // [RL15]
	wire [8:0] rdat_w = dmask(rsh_q[8:0], n_w); // [RL16]
	wire rpe_w = pen_w & (rsh_q[n_w] != parity(rdat_w, n_w, podd_w)); // [RL21]
	wire [utb_pkg::FIFO_W-1:0] entry_w = {rpe_w, dor_pend_q, ~rxd_w, rdat_w};
	wire [utb_pkg::FIFO_W-1:0] head_w = fifo_q[rp_q];

	always_ff @(posedge clk_i) begin
		if (rst_i || !rxen_w) begin
			rst_q <= utb_pkg::RX_IDLE;
			ridx_q <= 4'd0;
			rsh_q <= 10'h000;
		end else begin
			case (rst_q)
				utb_pkg::RX_IDLE: begin
					if (sync_w ? (rtick_w & ~rxd_w) : ~rxd_w) begin
						rst_q <= sync_w ? utb_pkg::RX_BITS : utb_pkg::RX_START;
						ridx_q <= 4'd0;
					end
				end
				utb_pkg::RX_START: begin
					// mid-bit recheck rejects glitches as false starts
					if (rtick_w) rst_q <= rxd_w ? utb_pkg::RX_IDLE : utb_pkg::RX_BITS; // [RL13]
				end
				utb_pkg::RX_BITS: begin
					if (rtick_w) begin
						rsh_q[ridx_q] <= rxd_w; // [RL13]
						ridx_q <= ridx_q + 4'd1;
						if (ridx_q + 4'd1 == rlen_w) rst_q <= utb_pkg::RX_STOP;
					end
				end
				utb_pkg::RX_STOP: begin
					if (rtick_w) rst_q <= utb_pkg::RX_IDLE; // [RL14]
				end
				default: rst_q <= utb_pkg::RX_IDLE;
			endcase
		end
	end

	wire rx_start_w = (rst_q == utb_pkg::RX_IDLE) & ~rxd_w;
	always_ff @(posedge clk_i) begin
		if (rst_i || rx_start_w) rdiv_q <= {1'b0, baud_q[11:1]};
		else if (rtick_w) rdiv_q <= baud_q;
		else rdiv_q <= rdiv_q - 12'h001;
	end

	// fifo flushes whenever the receiver is disabled
	always_ff @(posedge clk_i) begin
		if (rst_i || !rxen_w) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'd0;
			dor_pend_q <= 1'b0;
		end else begin
			if (push_w) wp_q <= ~wp_q; // [RL23]
			if (pop_w) rp_q <= ~rp_q; // [RL17]
			cnt_q <= cnt_q + 2'(push_w) - 2'(pop_w);
			if (done_w & ~push_w) dor_pend_q <= 1'b1;
			else if (push_w) dor_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push_w) fifo_q[wp_q] <= entry_w; // [RL17]
	end

	////////////////////////////////////////////////////////////////////////
	// registers and read mux
	wire has_w = cnt_q != 2'd0;
	wire [7:0] stat_w = {has_w, txc_q, udre_w, has_w & head_w[9], has_w & head_w[10],
		has_w & head_w[11], 2'b00}; // [RL23] [RL1]
	wire [7:0] ctlb_rd_w = {ctlb_q[7:2], has_w & head_w[8], ctlb_q[0]}; // [RL17]
	logic [31:0] rmux_w;
	always_comb begin
		rmux_w = 32'h0000_0000;
		if (hi_zero_w) begin
			case (ra_w)
				utb_pkg::REG_DATA: rmux_w = {24'h0, has_w ? head_w[7:0] : 8'h00}; // [RL16]
				utb_pkg::REG_STAT: rmux_w = {24'h0, stat_w};
				utb_pkg::REG_CTLB: rmux_w = {24'h0, ctlb_rd_w};
				utb_pkg::REG_CTLC: rmux_w = {24'h0, ctlc_q};
				utb_pkg::REG_BAUD: rmux_w = {20'h0, baud_q};
				default: rmux_w = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			ctlb_q <= utb_pkg::CTLB_RST;
			ctlc_q <= utb_pkg::CTLC_RST;
			baud_q <= utb_pkg::BAUD_RST;
		end else begin
			ack_q <= req_w & ~ack_q;
			if (avs_read_i & ~ack_q) rdata_q <= rmux_w;
			if (wr_ctlb_w) ctlb_q <= {1'b0, wd_w[6:2], 1'b0, wd_w[0]};
			if (wr_ctlc_w) ctlc_q <= {1'b0, wd_w[6:1], 1'b0};
			if (wr_baud_w) baud_q <= {avs_byteenable_i[1] ? avs_writedata_i[11:8]
				: baud_q[11:8], wd_w};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	udre_track_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_data_w && udre_w && !tload_w |=> !udre_w) else $error("empty flag not cleared"); // [RL4]
	empty_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_data_w && !tfull_q |=> !tx_empty_irq_o) else $error("empty irq after write"); // [RL3]
	txc_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tlast_w && !tfull_q |=> txc_q) else $error("complete flag not set"); // [RL6]
	txc_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		txc_q && tx_complete_irq_ack_i && !txc_set_w |=> !txc_q)
		else $error("complete flag not cleared"); // [RL7]
	txc_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(txc_q) && ctlb_q[6] && global_irq_enable_i |-> tx_complete_irq_o)
		else $error("complete irq missing"); // [RL8]
	pin_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(tbusy_q || tfull_q) |-> serial_out_oe_o) else $error("pin released early"); // [RL10]
	start_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tload_w |=> !serial_out_pin_o) else $error("no start bit"); // [RL22]
	rxc_fifo_a: assert property (@(posedge clk_i) disable iff (rst_i)
		push_w && !pop_w && cnt_q == 2'd0 |=> stat_w[7] && cnt_q == 2'd1)
		else $error("receive flag wrong"); // [RL23]
	rx_flush_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rxen_w |=> cnt_q == 2'd0) else $error("fifo not flushed"); // [RL11]
	rxc_drain_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pop_w && !push_w && cnt_q == 2'd1 |=> !stat_w[7])
		else $error("receive flag stuck"); // [RL23]
	bus_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
		req_w && !ack_q |=> !avs_waitrequest_o) else $error("wait too long");
	frame_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tload_w |-> tlen_w >= 4'd7) else $error("frame too short"); // [RL9]
	tx_frame_c: cover property (@(posedge clk_i) disable iff (rst_i) tlast_w);
	rx_frame_c: cover property (@(posedge clk_i) disable iff (rst_i) push_w);
	rx_full_c: cover property (@(posedge clk_i) disable iff (rst_i) full_w && done_w);
	b2b_tx_c: cover property (@(posedge clk_i) disable iff (rst_i) tlast_w && tfull_q);
	rx_parity_c: cover property (@(posedge clk_i) disable iff (rst_i) push_w && rpe_w);
endmodule

// file: testbench/utb_peer.sv
// remote serial transceiver model on the far side of the line pins
`timescale 1ns/1ps
module utb_peer (
	// line pins as seen from the far side
	input  wire logic line_i,
	output logic      line_o,
	output logic      sclk_o
);
	// async bit time matches the reset baud divisor at 20 MHz
	localparam int BIT_NS = 500;
	initial begin
		line_o = 1'b1;
		sclk_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// start, n bits lsb first, one stop of value stp; sclk only runs within a frame
	task automatic send(input logic [11:0] v, input int n, input logic stp, input logic sync);
		for (int i = 0; i < n + 2; i++) begin
			line_o <= (i == 0) ? 1'b0 : ((i > n) ? stp : v[i-1]);
			if (sync) begin
				#200 sclk_o <= 1'b1;
				#200 sclk_o <= 1'b0;
			end else begin
				#(BIT_NS);
			end
		end
		// the line has a pull-up, so it rests high
		line_o <= 1'b1;
	endtask
	// waits for a start bit, then takes n bits at mid-bit, lsb first
	task automatic recv(input int n, output logic [11:0] v);
		v = '0;
		@(negedge line_i);
		#(BIT_NS / 2);
		for (int i = 0; i < n; i++) begin
			#(BIT_NS);
			v[i] = line_i;
		end
	endtask
endmodule

// file: testbench/utb_usart_bench.sv
// self-checking bench for the serial buffer block against a remote line model
`timescale 1ns/1ps
module utb_usart_bench;
	// stimulus
	logic        clk_i;
	logic        rst_i;
	logic [2:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic        gie;
	logic        txc_ack;
	// observed
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        tx_empty_irq_o;
	logic        tx_complete_irq_o;
	logic        serial_out_pin_o;
	logic        serial_out_oe_o;
	logic        serial_in_owned_o;
	logic        rx_line;
	logic        sync_clk;
	logic        tx_line;
	logic [11:0] f;
	logic [11:0] g;
	int          err_count;
	int          num_checks;
	// released output pin is pulled up
	assign tx_line = serial_out_oe_o ? serial_out_pin_o : 1'b1;
	utb_usart utb_usart_i (
		.clk_i                 (clk_i),
		.rst_i                 (rst_i),
		.avs_address_i         (avs_address),
		.avs_read_i            (avs_read),
		.avs_write_i           (avs_write),
		.avs_byteenable_i      (4'hF),
		.avs_writedata_i       (avs_writedata),
		.avs_readdata_o        (avs_readdata_o),
		.avs_waitrequest_o     (avs_waitrequest_o),
		.global_irq_enable_i   (gie),
		.tx_complete_irq_ack_i (txc_ack),
		.tx_empty_irq_o        (tx_empty_irq_o),
		.tx_complete_irq_o     (tx_complete_irq_o),
		.serial_in_pin_i       (rx_line),
		.sync_clock_pin_i      (sync_clk),
		.serial_out_pin_o      (serial_out_pin_o),
		.serial_out_oe_o       (serial_out_oe_o),
		.serial_in_owned_o     (serial_in_owned_o)
	);
	utb_peer utb_peer_i (
		.line_i (tx_line),
		.line_o (rx_line),
		.sclk_o (sync_clk)
	);
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		q = avs_readdata_o;
		if (n == 50) begin
			err_count++;
			$display("mismatch waitrequest expected 0 seen 1");
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [2:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(nm, exp, q);
	endtask
	task automatic wait_txc();
		for (int n = 0; n < 200 && tx_complete_irq_o !== 1'b1; n++) @(posedge clk_i);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("quiet_outs", 32'h0, {tx_empty_irq_o, tx_complete_irq_o, serial_out_oe_o});
		chk("owned", 32'h0, serial_in_owned_o);
		rd(utb_pkg::REG_STAT, 32'h20, "stat");
		rd(utb_pkg::REG_CTLB, {24'h0, utb_pkg::CTLB_RST}, "ctlb");
		rd(utb_pkg::REG_CTLC, {24'h0, utb_pkg::CTLC_RST}, "ctlc");
		rd(utb_pkg::REG_BAUD, {20'h0, utb_pkg::BAUD_RST}, "baud");
		wr(3'h5, 8'hFF);
		rd(3'h5, 32'h0, "unmapped");
		$display("t_reset done");
	endtask
	task automatic t_tx_even();
		wr(utb_pkg::REG_CTLC, 8'h26);
		wr(utb_pkg::REG_CTLB, 8'h68);
		gie <= 1'b1;
		fork
			begin
				utb_peer_i.recv(10, f);
				utb_peer_i.recv(10, g);
			end
			begin
				wr(utb_pkg::REG_DATA, 8'hA5);
				wr(utb_pkg::REG_DATA, 8'h3C);
				chk("empty_irq_full", 32'h0, tx_empty_irq_o);
				rd(utb_pkg::REG_STAT, 32'h00, "stat_full");
			end
		join
		chk("frame_a5", 32'h2A5, f);
		chk("frame_3c", 32'h23C, g);
		wait_txc();
		chk("txc_irq", 32'h1, tx_complete_irq_o);
		chk("empty_irq", 32'h1, tx_empty_irq_o);
		txc_ack <= 1'b1;
		@(posedge clk_i);
		txc_ack <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("txc_ack", 32'h0, tx_complete_irq_o);
		$display("t_tx_even done");
	endtask
	task automatic t_tx_odd();
		wr(utb_pkg::REG_CTLC, 8'h30);
		wr(utb_pkg::REG_CTLB, 8'h48);
		fork
			begin
				utb_peer_i.recv(7, f);
				utb_peer_i.recv(7, g);
			end
			begin
				wr(utb_pkg::REG_DATA, 8'hFF);
				wr(utb_pkg::REG_DATA, 8'hE0);
				wr(utb_pkg::REG_CTLB, 8'h40);
				chk("oe_pending", 32'h1, serial_out_oe_o);
			end
		join
		chk("frame_odd5", 32'h05F, f);
		chk("frame_queued", 32'h060, g);
		wait_txc();
		chk("txc_set", 32'h1, tx_complete_irq_o);
		chk("oe_released", 32'h0, serial_out_oe_o);
		wr(utb_pkg::REG_STAT, 8'h40);
		rd(utb_pkg::REG_STAT, 32'h20, "stat_w1c");
		$display("t_tx_odd done");
	endtask
	task automatic t_tx_nine();
		wr(utb_pkg::REG_CTLC, 8'h0E);
		wr(utb_pkg::REG_CTLB, 8'h6D);
		chk("empty_irq_idle", 32'h1, tx_empty_irq_o);
		fork
			utb_peer_i.recv(11, f);
			begin
				wr(utb_pkg::REG_DATA, 8'h5A);
				wr(utb_pkg::REG_CTLB, 8'h4D);
				chk("empty_irq_off", 32'h0, tx_empty_irq_o);
			end
		join
		chk("txc_stop2", 32'h0, tx_complete_irq_o);
		chk("frame_nine", 32'h75A, f);
		wait_txc();
		chk("txc_nine", 32'h1, tx_complete_irq_o);
		wr(utb_pkg::REG_STAT, 8'h40);
		$display("t_tx_nine done");
	endtask
	task automatic t_rx_nine();
		wr(utb_pkg::REG_CTLC, 8'h0E);
		wr(utb_pkg::REG_CTLB, 8'h14);
		chk("rx_owned", 32'h1, serial_in_owned_o);
		utb_peer_i.send(12'h1C3, 9, 1'b1, 1'b0);
		utb_peer_i.send(12'h05A, 9, 1'b0, 1'b0);
		@(posedge clk_i);
		rd(utb_pkg::REG_STAT, 32'hA0, "stat_e1");
		rd(utb_pkg::REG_CTLB, 32'h16, "ninth_e1");
		rd(utb_pkg::REG_DATA, 32'h0C3, "data_e1");
		rd(utb_pkg::REG_STAT, 32'hB0, "stat_e2");
		rd(utb_pkg::REG_CTLB, 32'h14, "ninth_e2");
		rd(utb_pkg::REG_DATA, 32'h05A, "data_e2");
		rd(utb_pkg::REG_STAT, 32'h20, "stat_drained");
		$display("t_rx_nine done");
	endtask
	task automatic t_rx_parity();
		wr(utb_pkg::REG_CTLC, 8'h36);
		wr(utb_pkg::REG_CTLB, 8'h10);
		utb_peer_i.send(12'h0A5, 9, 1'b1, 1'b0);
		utb_peer_i.send(12'h1A5, 9, 1'b1, 1'b0);
		@(posedge clk_i);
		rd(utb_pkg::REG_STAT, 32'hA4, "stat_pe");
		rd(utb_pkg::REG_DATA, 32'h0A5, "data_pe");
		rd(utb_pkg::REG_STAT, 32'hA0, "stat_ok");
		rd(utb_pkg::REG_DATA, 32'h0A5, "data_ok");
		$display("t_rx_parity done");
	endtask
	task automatic t_rx_sync();
		wr(utb_pkg::REG_CTLC, 8'h42);
		wr(utb_pkg::REG_CTLB, 8'h10);
		utb_peer_i.send(12'h02B, 6, 1'b1, 1'b1);
		@(posedge clk_i);
		rd(utb_pkg::REG_STAT, 32'hA0, "stat_sync");
		rd(utb_pkg::REG_DATA, 32'h02B, "data_six");
		wr(utb_pkg::REG_CTLB, 8'h00);
		chk("rx_released", 32'h0, serial_in_owned_o);
		$display("t_rx_sync done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		err_count = 0;
		num_checks = 0;
		rst_i = 1'b1;
		avs_address = 3'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		gie = 1'b0;
		txc_ack = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_tx_even();
		t_tx_odd();
		t_tx_nine();
		t_rx_nine();
		t_rx_parity();
		t_rx_sync();
		end_sim();
	end
	// the whole run needs under two thousand cycles; this cuts a hang short
	initial begin
		#1000000;
		err_count++;
		end_sim();
	end
endmodule
